// ===== bench/tb_tsq_top.sv
// Self-checking bench of the trace sequencer top
`timescale 1ns/10ps
`default_nettype none
module tb_tsq_top;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h0;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic TRIGGER;
    logic STORE;
    logic [63:0] SAMPLE;
    wire [63:0] POD_DATA;
    wire CLK_J;
    wire CLK_K;
    wire CLK_L;
    wire QUAL_N;
    logic [32:0] apb_q[$];
    logic [64:0] smp_q[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int i;

    tsq_top dut_u (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .POD_DATA(POD_DATA),
        .CLK_J(CLK_J), .CLK_K(CLK_K), .CLK_L(CLK_L), .QUAL_N(QUAL_N),
        .TRIGGER(TRIGGER), .STORE(STORE), .SAMPLE(SAMPLE));
    tsq_probe_model model_u (.pod_data(POD_DATA), .clk_j(CLK_J),
        .clk_k(CLK_K), .clk_l(CLK_L), .qual_n(QUAL_N));

    always #5 CLK = ~CLK;

    task automatic chk(input string nm, input logic [64:0] s, x);
        begin
            comparisons++;
            if (s !== x)
            begin
                n_mismatch++;
                $display("wrong value %s expected %h seen %h", nm, x, s);
            end
        end
    endtask

    // One APB transfer; the answer is noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e);
        begin
            @(posedge CLK);
            apb_q.push_back(e);
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= d;
            @(posedge CLK);
            PENABLE <= 1'b1;
            @(posedge CLK);
            while (PREADY !== 1'b1)
                @(posedge CLK);
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {1'b0, x});
    endtask

    task automatic st(input logic [31:0] x);
        rd(tsq_pkg::ADDR_STATUS, x);
    endtask

    task automatic cmd(input logic [31:0] d);
        wr(tsq_pkg::ADDR_CMD, d);
    endtask

    // Pods: 1 demux rise N, 2 mixed fall N, 3 mixed both N, 4 mixed rise J
    task automatic send_frame(input logic cfg);
        logic [63:0] a, b, c, d, x;
        begin
            a = {$urandom, $urandom};
            b = {$urandom, $urandom};
            c = {$urandom, $urandom};
            d = {$urandom, $urandom};
            x = cfg ? {d[63:56], a[55:48], d[47:40], a[39:32], d[31:24],
                b[23:16], c[7:0], c[7:0]} : d;
            smp_q.push_back({cfg, x});
            model_u.frame(a, b, c, d);
        end
    endtask

    always @(negedge CLK)
    begin
        if (PREADY === 1'b1)
            chk("apb", 65'({PSLVERR, PRDATA}),
                65'(apb_q.pop_front()));
        if (STORE === 1'b1)
            chk("sample", {TRIGGER, SAMPLE}, smp_q.pop_front());
    end

    task automatic conclude;
        begin
            $display("comparisons %0d mismatches %0d", comparisons,
                n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial
    begin
        #50000;
        n_mismatch++;
        conclude;
    end

    initial
    begin
        void'($urandom(32'h991e));
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        st(32'h12);
        rd(tsq_pkg::ADDR_SLAVE, 32'h0);
        apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
        $display("test reset done");
        wr(tsq_pkg::ADDR_SLAVE, 32'h1);
        st(32'h2012);
        rd(tsq_pkg::ADDR_SLAVE, 32'h0);
        $display("test slave reject done");
        wr(tsq_pkg::ADDR_GLOBAL, 32'h9);
        cmd(32'h12);
        st(32'h23);
        wr(tsq_pkg::ADDR_TSEL, 32'h0);
        rd(tsq_pkg::ADDR_TERM, 32'h16);
        cmd(32'h12);
        cmd(32'h12);
        st(32'h2034);
        repeat (4) cmd(32'h13);
        st(32'h2001);
        $display("test easy terms done");
        wr(tsq_pkg::ADDR_CTRL, 32'h1);
        st(32'h18);
        for (i = 0; i < 7; i++)
        begin
            wr(tsq_pkg::ADDR_TSEL, 32'(i));
            rd(tsq_pkg::ADDR_TERM, 32'h14);
        end
        cmd(32'h84);
        st(32'h78);
        cmd(32'h14);
        st(32'h2078);
        cmd(32'h12);
        st(32'h2078);
        wr(tsq_pkg::ADDR_CTRL, 32'h0);
        st(32'h01);
        $display("test complex done");
        wr(tsq_pkg::ADDR_SLAVE, 32'h054d_4946);
        rd(tsq_pkg::ADDR_SLAVE, 32'h054d_4946);
        wr(tsq_pkg::ADDR_CTRL, 32'h2);
        send_frame(1'b1);
        st(32'h1001);
        wr(tsq_pkg::ADDR_SLAVE, 32'h4444_4444);
        send_frame(1'b0);
        repeat (4) @(posedge CLK);
        chk("pending", 65'(apb_q.size() + smp_q.size()), 65'h0);
        $display("test link done");
        conclude;
    end
endmodule
`default_nettype wire

// ===== bench/tsq_probe_model.sv
// Model of the probed processor bus and the external probe clocks
`timescale 1ns/10ps
`default_nettype none
module tsq_probe_model (
    output var logic [63:0] pod_data,
    output var logic clk_j,
    output var logic clk_k,
    output var logic clk_l,
    output var logic qual_n
);
    initial
    begin
        pod_data = 64'h0;
        clk_j = 1'b0;
        clk_k = 1'b0;
        clk_l = 1'b0;
        qual_n = 1'b0;
    end

    // One 160 ns master period; slave clocks rest low between frames
    // Emulation pods are slave-clocked by N, probe clocks feed pod 4 only
    task automatic frame(input logic [63:0] a, b, c, d);
        begin
            qual_n <= 1'b1;
            pod_data <= a;
            clk_j <= 1'b1;
            clk_k <= 1'b1;
            #20;
            pod_data <= b;
            qual_n <= 1'b0;
            clk_j <= 1'b0;
            clk_k <= 1'b0;
            #20;
            pod_data <= c;
            qual_n <= 1'b1;
            clk_j <= 1'b1;
            clk_k <= 1'b1;
            #20;
            qual_n <= 1'b0;
            clk_j <= 1'b0;
            clk_k <= 1'b0;
            #20;
            pod_data <= d;
            clk_l <= 1'b1;
            #80;
            clk_l <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/tsq_top_asserts.sv
// Port-level checker of the trace sequencer top, bound into it
`timescale 1ns/10ps
`default_nettype none
module tsq_top_asserts (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [63:0] POD_DATA,
    input wire logic CLK_J,
    input wire logic CLK_K,
    input wire logic CLK_L,
    input wire logic QUAL_N,
    input wire logic TRIGGER,
    input wire logic STORE,
    input wire logic [63:0] SAMPLE
);
    logic l_q;
    logic [3:0] since_q;
    wire logic [3:0] since_d;
    wire logic bad_addr;

    assign bad_addr = (PADDR > 8'h20) || (PADDR[1:0] != 2'h0);
    // Cycles since the master clock pin was seen rising, saturating
    assign since_d = (CLK_L && !l_q) ? 4'h0 :
        since_q + {3'h0, since_q != 4'hf};

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            l_q <= 1'b0;
            since_q <= 4'hf;
        end
        else
        begin
            l_q <= CLK_L;
            since_q <= since_d;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_after_master;
        since_q >= 4'h2 && since_q <= 4'h7;
    endsequence

    a_ready_next: assert property (s_setup |=> PREADY)
        else $error("no ready after setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_err_unmapped: assert property (s_setup ##0 bad_addr |=> PSLVERR)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_setup ##0 !bad_addr |=> !PSLVERR)
        else $error("mapped access refused");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_rdata_idle: assert property (
        !(PREADY && !PWRITE) |-> PRDATA == 32'h0)
        else $error("read data outside read answer");
    a_trig_pulse: assert property (TRIGGER |=> !TRIGGER)
        else $error("trigger longer than one cycle");
    a_trig_master: assert property (TRIGGER |-> s_after_master)
        else $error("trigger not tied to a sample");
    a_store_master: assert property (STORE |-> s_after_master)
        else $error("store not tied to a sample");
    a_sample_master: assert property (
        $changed(SAMPLE) |-> s_after_master)
        else $error("sample changed without master clock");
    a_quiet_reset: assert property (
        $rose(RST_B) |-> SAMPLE == 64'h0 && !STORE)
        else $error("outputs not clear after reset");
endmodule

bind tsq_top tsq_top_asserts chk_u (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .POD_DATA(POD_DATA), .CLK_J(CLK_J), .CLK_K(CLK_K), .CLK_L(CLK_L),
    .QUAL_N(QUAL_N), .TRIGGER(TRIGGER), .STORE(STORE), .SAMPLE(SAMPLE));
`default_nettype wire

// ===== common/tsq_pkg.sv
// Shared constants and carrier types of the trace sequencer block
package tsq_pkg;
    localparam int unsigned NUM_PODS = 4;
    localparam int unsigned POD_W = 16;
    localparam int unsigned LOW_W = 8;
    localparam int unsigned NUM_SRC = 5;
    localparam int unsigned MAX_TERMS = 8;
    localparam int unsigned EASY_MAX = 4;
    localparam logic [3:0] CPLX_RST_TRIG = 4'h2;
    localparam logic [3:0] CPLX_TRIG_MIN = 4'h2;
    localparam logic [3:0] CPLX_TRIG_MAX = 4'h8;
    localparam logic [3:0] EASY_X_MIN = 4'h1;
    localparam logic [3:0] PWRUP_TERMS = 4'h2;

    // Byte offsets on the register bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_SLAVE = 8'h08;
    localparam logic [7:0] ADDR_GLOBAL = 8'h0c;
    localparam logic [7:0] ADDR_PAT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_TSEL = 8'h18;
    localparam logic [7:0] ADDR_TERM = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // Field positions
    localparam int unsigned CTRL_CPLX = 0;
    localparam int unsigned CTRL_RUN = 1;
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_X_LSB = 4;
    localparam int unsigned POD_CFG_W = 8;
    localparam int unsigned GLB_STO_LSB = 0;
    localparam int unsigned GLB_ELIF_LSB = 2;
    localparam int unsigned ST_CNT_LSB = 0;
    localparam int unsigned ST_TRIG_LSB = 4;
    localparam int unsigned ST_LVL_LSB = 8;
    localparam int unsigned ST_TRIGD = 12;
    localparam int unsigned ST_ERR = 13;

    typedef enum logic [1:0] {SCK_OFF, SCK_MIXED, SCK_DEMUX} tsq_smode_t;
    typedef enum logic [1:0] {EDG_NONE, EDG_RISE, EDG_FALL, EDG_BOTH}
        tsq_edge_t;
    // Sources: 0 J probe, 1 K probe, 2 L emulation, 3 M unused, 4 N qual
    typedef enum logic [2:0] {SRC_J, SRC_K, SRC_L, SRC_M, SRC_N} tsq_src_t;
    typedef enum logic [1:0] {Q_NEVER, Q_ANY, Q_PAT, Q_NPAT} tsq_qual_t;
    typedef enum logic [2:0] {OP_NOP, OP_RESET, OP_INSERT, OP_DELETE,
        OP_TRIG} tsq_op_t;

    typedef struct packed {
        logic pad;
        tsq_src_t src;
        tsq_edge_t edge_sel;
        tsq_smode_t mode;
    } tsq_pod_cfg_t;

    typedef struct packed {
        tsq_qual_t store;
        tsq_qual_t prim;
        tsq_qual_t sec;
    } tsq_term_t;

    localparam tsq_pod_cfg_t POD_CFG_RST = '{1'b0, SRC_J, EDG_NONE, SCK_OFF};
    localparam tsq_term_t TERM_MID = '{Q_ANY, Q_ANY, Q_NEVER};
    localparam tsq_term_t TERM_LAST = '{Q_ANY, Q_NEVER, Q_NEVER};
endpackage

// ===== rtl/tsq_pod.sv
// One analyzer pod with slave-clock latching of its lower byte
`timescale 1ns/10ps
`default_nettype none
module tsq_pod (
    input wire logic clk,
    input wire logic rst_b,
    input wire tsq_pkg::tsq_pod_cfg_t cfg,
    input wire logic [tsq_pkg::POD_W-1:0] data,
    input wire logic sck_rise,
    input wire logic sck_fall,
    input wire logic master_evt,
    output var logic [tsq_pkg::POD_W-1:0] capt_q
);
    localparam int unsigned LW = tsq_pkg::LOW_W;
    logic [LW-1:0] low_q;
    logic seen_q;
    logic on;
    logic edge_hit;
    logic take;
    logic [LW-1:0] low_live;
    logic [tsq_pkg::POD_W-1:0] pod_view;

    assign on = cfg.mode != tsq_pkg::SCK_OFF;
    assign edge_hit = on &&
        (((cfg.edge_sel == tsq_pkg::EDG_RISE ||
           cfg.edge_sel == tsq_pkg::EDG_BOTH) && sck_rise) ||
         ((cfg.edge_sel == tsq_pkg::EDG_FALL ||
           cfg.edge_sel == tsq_pkg::EDG_BOTH) && sck_fall));
    // Mixed keeps only the first slave edge since the last master edge
    assign take = edge_hit &&
        !(cfg.mode == tsq_pkg::SCK_MIXED && seen_q);
    assign low_live = seen_q ? low_q : data[LW-1:0];
    assign pod_view = !on ? data :
        (cfg.mode == tsq_pkg::SCK_DEMUX) ? {low_live, low_live}
        : {data[tsq_pkg::POD_W-1:LW], low_live};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            low_q <= '0;
            seen_q <= 1'b0;
            capt_q <= '0;
        end
        else
        begin
            if (take)
                low_q <= data[LW-1:0];
            if (master_evt)
            begin
                capt_q <= pod_view;
                seen_q <= 1'b0;
            end
            else if (take)
                seen_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/tsq_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module tsq_sync #(
    parameter int unsigned W = 1
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/tsq_top.sv
// Trace sequencer with slave-clock pods, reached over APB
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tsq_top (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output var logic [31:0] PRDATA,
    output var logic PREADY,
    output var logic PSLVERR,
    input wire logic [63:0] POD_DATA,
    input wire logic CLK_J,
    input wire logic CLK_K,
    input wire logic CLK_L,
    input wire logic QUAL_N,
    output var logic TRIGGER,
    output var logic STORE,
    output var logic [63:0] SAMPLE
);
    localparam int unsigned NP = tsq_pkg::NUM_PODS;
    localparam int unsigned NT = tsq_pkg::MAX_TERMS;

    logic [63:0] pod_s;
    logic [3:0] clk_s;
    logic [tsq_pkg::NUM_SRC-1:0] src_now;
    logic [tsq_pkg::NUM_SRC-1:0] src_prev_q;
    logic master_evt;
    logic samp_evt_q;
    logic [63:0] capt;

    tsq_pkg::tsq_pod_cfg_t pod_cfg_q [NP];
    tsq_pkg::tsq_term_t term_q [NT];
    logic cplx_q;
    logic run_q;
    tsq_pkg::tsq_qual_t gsto_q;
    tsq_pkg::tsq_qual_t gelif_q;
    logic [31:0] pat_q;
    logic [31:0] mask_q;
    logic [2:0] tsel_q;
    logic [3:0] cnt_q;
    logic [2:0] trig_q;
    logic [2:0] lvl_q;
    logic trigd_q;
    logic err_q;

    function automatic logic qmatch(input tsq_pkg::tsq_qual_t q,
        input logic [31:0] s, input logic [31:0] p, input logic [31:0] m);
        logic hit;
        hit = ((s ^ p) & m) == 32'h0000_0000;
        case (q)
            tsq_pkg::Q_ANY: qmatch = 1'b1;
            tsq_pkg::Q_PAT: qmatch = hit;
            tsq_pkg::Q_NPAT: qmatch = !hit;
            default: qmatch = 1'b0;
        endcase
    endfunction

    // Pins cross into CLK before any use
    tsq_sync #(.W(64)) u_sync_pod (.CLK(CLK), .RST_B(RST_B),
        .d(POD_DATA), .q(pod_s));
    tsq_sync #(.W(4)) u_sync_clk (.CLK(CLK), .RST_B(RST_B),
        .d({QUAL_N, CLK_L, CLK_K, CLK_J}), .q(clk_s));

    // Emulator makes L and N, M stays quiet
    assign src_now = {clk_s[3], 1'b0, clk_s[2], clk_s[1], clk_s[0]};
    assign master_evt = clk_s[2] && !src_prev_q[tsq_pkg::SRC_L];

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++)
        begin : g_pod
            logic sel_now;
            logic sel_prev;
            assign sel_now = src_now[pod_cfg_q[gp].src];
            assign sel_prev = src_prev_q[pod_cfg_q[gp].src];
            tsq_pod u_pod (
                .clk(CLK),
                .rst_b(RST_B),
                .cfg(pod_cfg_q[gp]),
                .data(pod_s[gp*16 +: 16]),
                .sck_rise(sel_now && !sel_prev),
                .sck_fall(!sel_now && sel_prev),
                .master_evt(master_evt),
                .capt_q(capt[gp*16 +: 16])
            );
        end
    endgenerate

    // Bus decode
    logic setup;
    logic wr_acc;
    logic addr_ok;
    logic [2:0] op;
    logic [3:0] cmd_x;
    logic [2:0] pos;
    logic [3:0] last_full;
    logic [2:0] last_idx;
    logic slave_ok;
    logic ins_ok;
    logic del_ok;
    logic trg_ok;
    logic do_reset;
    logic new_cplx;
    logic [31:0] rd_mux;
    logic [31:0] slave_rd;
    logic [31:0] status_rd;

    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
    assign addr_ok = PADDR <= tsq_pkg::ADDR_STATUS && PADDR[1:0] == 2'b00;
    assign op = PWDATA[tsq_pkg::CMD_OP_LSB +: 3];
    assign cmd_x = PWDATA[tsq_pkg::CMD_X_LSB +: 4];
    assign pos = 3'(cmd_x - 4'h1);
    assign last_full = cplx_q ? 4'(NT) : cnt_q;
    assign last_idx = 3'(last_full - 4'h1);
    assign new_cplx = PWDATA[tsq_pkg::CTRL_CPLX];

    // Slave mode needs an edge choice on every active pod
    always_comb
    begin
        slave_ok = 1'b1;
        for (int i = 0; i < NP; i++)
            if (PWDATA[i*8 +: 2] != 2'(tsq_pkg::SCK_OFF) &&
                PWDATA[i*8+2 +: 2] == 2'(tsq_pkg::EDG_NONE))
                slave_ok = 1'b0;
    end

    // Insert only contiguously, within range
    assign ins_ok = !cplx_q && cmd_x >= tsq_pkg::EASY_X_MIN &&
        cmd_x <= 4'(tsq_pkg::EASY_MAX) && cnt_q < 4'(tsq_pkg::EASY_MAX) &&
        cmd_x <= cnt_q + 4'h1;
    assign del_ok = !cplx_q && cmd_x >= tsq_pkg::EASY_X_MIN &&
        cmd_x <= cnt_q && cnt_q > 4'h1;
    assign trg_ok = cplx_q && cmd_x >= tsq_pkg::CPLX_TRIG_MIN &&
        cmd_x <= tsq_pkg::CPLX_TRIG_MAX;
    assign do_reset = wr_acc && ((PADDR == tsq_pkg::ADDR_CMD &&
        op == 3'(tsq_pkg::OP_RESET)) ||
        (PADDR == tsq_pkg::ADDR_CTRL && new_cplx != cplx_q));

    always_comb
    begin
        slave_rd = '0;
        for (int i = 0; i < NP; i++)
            slave_rd[i*8 +: 8] = pod_cfg_q[i];
    end
    assign status_rd = {18'h0, err_q, trigd_q, 1'b0, lvl_q, 1'b0, trig_q,
        cnt_q};
    assign rd_mux =
        PADDR == tsq_pkg::ADDR_CTRL ? {30'h0, run_q, cplx_q} :
        PADDR == tsq_pkg::ADDR_SLAVE ? slave_rd :
        PADDR == tsq_pkg::ADDR_GLOBAL ? {28'h0, gelif_q, gsto_q} :
        PADDR == tsq_pkg::ADDR_PAT ? pat_q :
        PADDR == tsq_pkg::ADDR_MASK ? mask_q :
        PADDR == tsq_pkg::ADDR_TSEL ? {29'h0, tsel_q} :
        PADDR == tsq_pkg::ADDR_TERM ? {26'h0, term_q[tsel_q]} :
        PADDR == tsq_pkg::ADDR_STATUS ? status_rd : 32'h0000_0000;

    // No wait state: answer in the cycle after setup
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end
        else
        begin
            PREADY <= setup;
            PSLVERR <= setup && !addr_ok;
            PRDATA <= (setup && !PWRITE && addr_ok) ? rd_mux : '0;
        end
    end

    // Settings storage
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < NP; i++)
                pod_cfg_q[i] <= tsq_pkg::POD_CFG_RST;
            cplx_q <= 1'b0;
            run_q <= 1'b0;
            gsto_q <= tsq_pkg::Q_ANY;
            gelif_q <= tsq_pkg::Q_NEVER;
            pat_q <= '0;
            mask_q <= '0;
            tsel_q <= '0;
            err_q <= 1'b0;
        end
        else if (wr_acc)
        begin
            err_q <= 1'b0;
            case (PADDR)
                tsq_pkg::ADDR_CTRL:
                begin
                    cplx_q <= new_cplx;
                    run_q <= PWDATA[tsq_pkg::CTRL_RUN];
                end
                tsq_pkg::ADDR_SLAVE:
                    if (slave_ok)
                        for (int i = 0; i < NP; i++)
                            pod_cfg_q[i] <= tsq_pkg::tsq_pod_cfg_t'(
                                PWDATA[i*8 +: 8]);
                    else
                        err_q <= 1'b1;
                tsq_pkg::ADDR_GLOBAL:
                begin
                    gsto_q <= tsq_pkg::tsq_qual_t'(PWDATA[1:0]);
                    gelif_q <= tsq_pkg::tsq_qual_t'(PWDATA[3:2]);
                end
                tsq_pkg::ADDR_PAT: pat_q <= PWDATA;
                tsq_pkg::ADDR_MASK: mask_q <= PWDATA;
                tsq_pkg::ADDR_TSEL: tsel_q <= PWDATA[2:0];
                tsq_pkg::ADDR_CMD:
                    err_q <= (op == 3'(tsq_pkg::OP_INSERT) && !ins_ok) ||
                        (op == 3'(tsq_pkg::OP_DELETE) && !del_ok) ||
                        (op == 3'(tsq_pkg::OP_TRIG) && !trg_ok);
                default: err_q <= 1'b0;
            endcase
            if (PADDR == tsq_pkg::ADDR_CTRL && new_cplx != cplx_q)
                gsto_q <= tsq_pkg::Q_ANY;
        end
    end

    // Term table and sequencer run
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < NT; i++)
                term_q[i] <= tsq_pkg::TERM_LAST;
            term_q[0] <= tsq_pkg::TERM_MID;
            cnt_q <= tsq_pkg::PWRUP_TERMS;
            trig_q <= 3'(tsq_pkg::PWRUP_TERMS - 4'h1);
            lvl_q <= '0;
            trigd_q <= 1'b0;
            TRIGGER <= 1'b0;
            STORE <= 1'b0;
            SAMPLE <= '0;
            src_prev_q <= '0;
            samp_evt_q <= 1'b0;
        end
        else
        begin
            src_prev_q <= src_now;
            samp_evt_q <= master_evt;
            TRIGGER <= 1'b0;
            STORE <= 1'b0;
            if (do_reset)
            begin
                lvl_q <= '0;
                trigd_q <= 1'b0;
                if (PADDR == tsq_pkg::ADDR_CTRL ? new_cplx : cplx_q)
                begin
                    for (int i = 0; i < NT; i++)
                        term_q[i] <= tsq_pkg::TERM_MID;
                    cnt_q <= 4'(NT);
                    trig_q <= 3'(tsq_pkg::CPLX_RST_TRIG - 4'h1);
                end
                else
                begin
                    term_q[0] <= tsq_pkg::TERM_MID;
                    cnt_q <= 4'h1;
                    trig_q <= 3'h0;
                end
            end
            else if (wr_acc && PADDR == tsq_pkg::ADDR_TERM)
                term_q[tsel_q] <= tsq_pkg::tsq_term_t'(PWDATA[5:0]);
            else if (wr_acc && PADDR == tsq_pkg::ADDR_CMD)
            begin
                if (op == 3'(tsq_pkg::OP_INSERT) && ins_ok)
                begin
                    for (int i = 1; i < NT; i++)
                        if (3'(i) > pos)
                            term_q[i] <= term_q[i-1];
                    term_q[pos] <= '{gsto_q,
                        (4'(pos) == cnt_q) ? tsq_pkg::Q_NEVER
                        : tsq_pkg::Q_ANY, gelif_q};
                    if (4'(pos) == cnt_q && pos != 3'h0)
                        term_q[pos-3'h1].prim <= tsq_pkg::Q_ANY;
                    cnt_q <= cnt_q + 4'h1;
                    trig_q <= 3'(cnt_q);
                end
                if (op == 3'(tsq_pkg::OP_DELETE) && del_ok)
                begin
                    for (int i = 0; i < NT - 1; i++)
                        if (3'(i) >= pos)
                            term_q[i] <= term_q[i+1];
                    if (4'(pos) == cnt_q - 4'h1)
                        term_q[pos-3'h1].prim <= tsq_pkg::Q_NEVER;
                    cnt_q <= cnt_q - 4'h1;
                    trig_q <= 3'(cnt_q - 4'h2);
                    lvl_q <= '0;
                end
                if (op == 3'(tsq_pkg::OP_TRIG) && trg_ok)
                    trig_q <= pos;
            end
            else if (samp_evt_q && run_q)
            begin
                SAMPLE <= capt;
                STORE <= qmatch(cplx_q ? term_q[lvl_q].store : gsto_q,
                    capt[31:0], pat_q, mask_q);
                if (trig_q == 3'h0 && !trigd_q)
                begin
                    trigd_q <= 1'b1;
                    TRIGGER <= 1'b1;
                end
                else if (lvl_q != 3'h0 && qmatch(
                    cplx_q ? term_q[lvl_q].sec : gelif_q,
                    capt[31:0], pat_q, mask_q))
                    lvl_q <= '0;
                else if (lvl_q != last_idx &&
                    qmatch(term_q[lvl_q].prim, capt[31:0], pat_q, mask_q))
                begin
                    lvl_q <= lvl_q + 3'h1;
                    if (lvl_q + 3'h1 == trig_q && !trigd_q)
                    begin
                        trigd_q <= 1'b1;
                        TRIGGER <= 1'b1;
                    end
                end
            end
            else if (!run_q)
            begin
                lvl_q <= '0;
                trigd_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
